// ==== dtg_defs.vh ====
`ifndef DTG_DEFS_VH
`define DTG_DEFS_VH
// register byte offsets on the axi4-lite slave
`define DTG_OFF_TXDATA 5'h00
`define DTG_OFF_CTRL 5'h04
`define DTG_OFF_STATUS 5'h08
`define DTG_OFF_RXDATA 5'h0C
`define DTG_OFF_TONE 5'h10
// control fields
`define DTG_CTL_TONE_OUTPUT_ENABLE 0
`define DTG_CTL_CPMODE 1
`define DTG_CTL_IRQEN 2
`define DTG_CTL_BURST 3
`define DTG_CTL_SINGLE 4
`define DTG_CTL_HIGHSEL 5
`define DTG_CTL_RESET 6'h00
// status fields
`define DTG_ST_IRQ 0
`define DTG_ST_TXRDY 1
`define DTG_ST_DV 2
`define DTG_ST_DSTEER 3
// timing: clock, reference, burst
`define DTG_CLK_HZ 40000000
`define DTG_REF_HZ_X1000 32'd3579545000
`define DTG_BURST_MS 51
`define DTG_CLK_PER_MS 40000
`define DTG_BURST_CYC (`DTG_BURST_MS * `DTG_CLK_PER_MS)
// guard times in clock cycles
`define DTG_GTP_CYC 1600000
`define DTG_GTA_CYC 1600000
// sine table segments
`define DTG_SEGS 32
`endif

// ==== dtg_tone_ctrl.v ====
`timescale 1ns/1ps
`include "dtg_defs.vh"
`default_nettype none
module dtg_tone_ctrl #(
  parameter GTP_CYC = `DTG_GTP_CYC,
  parameter GTA_CYC = `DTG_GTA_CYC,
  parameter BURST_CYC = `DTG_BURST_CYC,
  parameter REF_X1000 = `DTG_REF_HZ_X1000
) (
  input wire clock,
  input wire rst,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [4:0] s_axi_awaddr,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  output reg [1:0] s_axi_bresp,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  input wire [4:0] s_axi_araddr,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  input wire early_detect_out,
  input wire [3:0] detect_code,
  input wire cp_inband,
  output reg steer_guard_pin,
  output reg delayed_steer_n,
  output reg [3:0] receive_code_bits,
  output reg notify_or_progress_pin_oe,
  output reg [4:0] low_sine_addr,
  output reg [4:0] high_sine_addr,
  output reg low_active,
  output reg high_active
);

  // synchronisers for the pin-side inputs
  reg est_s1_r, est_s2_r, cp_s1_r, cp_s2_r;
  reg [3:0] code_s1_r, code_s2_r;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      est_s1_r <= 1'b0;
      est_s2_r <= 1'b0;
      cp_s1_r <= 1'b0;
      cp_s2_r <= 1'b0;
      code_s1_r <= 4'h0;
      code_s2_r <= 4'h0;
    end else begin
      est_s1_r <= early_detect_out;
      est_s2_r <= est_s1_r;
      cp_s1_r <= cp_inband;
      cp_s2_r <= cp_s1_r;
      code_s1_r <= detect_code;
      code_s2_r <= code_s1_r;
    end
  end

  // software-visible state
  reg [5:0] ctrl_r; // control bits
  reg [3:0] tx_code_r; // latched transmit code
  reg dv_r; // data valid
  reg txrdy_r; // transmitter ready
  reg irq_dv_r; // interrupt pending, receive
  reg irq_tx_r; // interrupt pending, transmit
  wire tone_output_enable = ctrl_r[`DTG_CTL_TONE_OUTPUT_ENABLE];
  wire cp_mode = ctrl_r[`DTG_CTL_CPMODE];
  wire irq_en = ctrl_r[`DTG_CTL_IRQEN];
  wire burst_en = ctrl_r[`DTG_CTL_BURST];

  // code to row/column: one-hot of four each (two of eight)
  function [7:0] dtg_two_of_eight;
    input [3:0] c;
    begin
      case (c)
        4'h1: dtg_two_of_eight = 8'h11;
        4'h2: dtg_two_of_eight = 8'h21;
        4'h3: dtg_two_of_eight = 8'h41;
        4'h4: dtg_two_of_eight = 8'h12;
        4'h5: dtg_two_of_eight = 8'h22;
        4'h6: dtg_two_of_eight = 8'h42;
        4'h7: dtg_two_of_eight = 8'h14;
        4'h8: dtg_two_of_eight = 8'h24;
        4'h9: dtg_two_of_eight = 8'h44;
        4'hA: dtg_two_of_eight = 8'h28;
        4'hB: dtg_two_of_eight = 8'h18;
        4'hC: dtg_two_of_eight = 8'h48;
        4'hD: dtg_two_of_eight = 8'h81;
        4'hE: dtg_two_of_eight = 8'h82;
        4'hF: dtg_two_of_eight = 8'h84;
        default: dtg_two_of_eight = 8'h88;
      endcase
    end
  endfunction

  // segment length (in reference ticks) for a one-hot group select
  function [7:0] dtg_seg_len;
    input [3:0] sel;
    input hi;
    begin
      case ({hi, sel})
        5'h01: dtg_seg_len = 8'hA0; // 697 hz
        5'h02: dtg_seg_len = 8'h92; // 770 hz
        5'h04: dtg_seg_len = 8'h84; // 852 hz
        5'h08: dtg_seg_len = 8'h76; // 941 hz
        5'h11: dtg_seg_len = 8'h5C; // 1209 hz
        5'h12: dtg_seg_len = 8'h54; // 1336 hz
        5'h14: dtg_seg_len = 8'h4C; // 1477 hz
        default: dtg_seg_len = 8'h44; // 1633 hz
      endcase
    end
  endfunction

  // axi4-lite: write address and data taken together, either order
  reg aw_hold_r, w_hold_r;
  reg [4:0] awaddr_r;
  reg [31:0] wdata_r;
  reg wstb_r; // low-byte strobe kept with held data
  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire aw_now = aw_hold_r || s_axi_awvalid;
  wire w_now = w_hold_r || s_axi_wvalid;
  wire [4:0] wa = aw_hold_r ? awaddr_r : s_axi_awaddr;
  wire [31:0] wd = w_hold_r ? wdata_r : s_axi_wdata;
  wire ws0 = w_hold_r ? wstb_r : s_axi_wstrb[0]; // no strobe, no effect, burst included
  wire wr_go = aw_now && w_now && !s_axi_bvalid;
  wire wr_tx = wr_go && ws0 && (wa == `DTG_OFF_TXDATA);
  wire wr_ctl = wr_go && ws0 && (wa == `DTG_OFF_CTRL);
  wire rd_go = s_axi_arvalid && s_axi_arready;
  wire rd_status = rd_go && (s_axi_araddr == `DTG_OFF_STATUS);

  // reference tick: fractional accumulator of 3.579545 mhz on 40 mhz
  localparam [31:0] REF_INC = REF_X1000 / 1000; // reference hz added per clock
  localparam [32:0] CLK_HZ = `DTG_CLK_HZ; // wrap point of the accumulator
  reg [31:0] ref_acc_r;
  wire [32:0] ref_sum = {1'b0, ref_acc_r} + {1'b0, REF_INC};
  wire ref_tick = (ref_sum >= CLK_HZ);
  // free-running reference, not gated by enable
  always @(posedge clock or posedge rst) begin
    if (rst)
      ref_acc_r <= 32'h0;
    else if (ref_tick)
      ref_acc_r <= ref_sum[31:0] - CLK_HZ[31:0];
    else
      ref_acc_r <= ref_sum[31:0];
  end

  // receive steering: one guard counter shared by present and absent
  reg [23:0] guard_cnt_r;
  reg steer_r; // validated tone present
  wire est_ok = est_s2_r && !cp_mode;
  // count up only while condition holds
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      guard_cnt_r <= 24'h0;
      steer_r <= 1'b0;
      receive_code_bits <= 4'h0;
    end else if (est_ok == steer_r) begin
      guard_cnt_r <= 24'h0;
    end else if (!steer_r && guard_cnt_r >= GTP_CYC[23:0] - 24'd1) begin
      guard_cnt_r <= 24'h0;
      steer_r <= 1'b1;
      receive_code_bits <= code_s2_r;
    end else if (steer_r && guard_cnt_r >= GTA_CYC[23:0] - 24'd1) begin
      guard_cnt_r <= 24'h0;
      steer_r <= 1'b0;
    end else begin
      guard_cnt_r <= guard_cnt_r + 24'd1;
    end
  end
  wire new_rx = !steer_r && est_ok == 1'b1 && guard_cnt_r >= GTP_CYC[23:0] - 24'd1;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      delayed_steer_n <= 1'b1;
      steer_guard_pin <= 1'b0;
    end else begin
      delayed_steer_n <= !steer_r;
      steer_guard_pin <= steer_r;
    end
  end

  // burst timer: tone phase then pause phase
  localparam BS_IDLE = 2'd0;
  localparam BS_TONE = 2'd1;
  localparam BS_PAUSE = 2'd2;
  reg [1:0] bst_r;
  reg [23:0] bcnt_r;
  wire [23:0] blen = cp_mode ? BURST_CYC[22:0] * 24'd2 : BURST_CYC[23:0];
  wire bdone = bcnt_r >= blen - 24'd1;
  wire tx_done = burst_en && (bst_r == BS_PAUSE) && bdone;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      bst_r <= BS_IDLE;
      bcnt_r <= 24'h0;
    end else if (wr_tx) begin
      bst_r <= BS_TONE;
      bcnt_r <= 24'h0;
    end else begin
      case (bst_r)
        BS_TONE: begin
          bcnt_r <= bdone ? 24'h0 : bcnt_r + 24'd1;
          if (bdone)
            bst_r <= BS_PAUSE;
        end
        // equal silent interval
        BS_PAUSE: begin
          bcnt_r <= bdone ? 24'h0 : bcnt_r + 24'd1;
          if (bdone)
            bst_r <= BS_IDLE;
        end
        default: begin
          bcnt_r <= 24'h0;
          bst_r <= BS_IDLE;
        end
      endcase
    end
  end

  // latch code, decode two of eight
  wire [7:0] sel8 = dtg_two_of_eight(tx_code_r);
  // enable gates transmission; burst adds tone window
  // transmit works in cp plus burst mode
  wire tx_on = tone_output_enable && (!burst_en || bst_r == BS_TONE);
  wire single = ctrl_r[`DTG_CTL_SINGLE];
  wire hi_sel = ctrl_r[`DTG_CTL_HIGHSEL];

  // row and column dividers feeding sine addresses
  reg [7:0] ldiv_r, hdiv_r;
  wire [7:0] lterm = dtg_seg_len(sel8[3:0], 1'b0);
  wire [7:0] hterm = dtg_seg_len(sel8[7:4], 1'b1);
  // terminal count resets and steps table
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      ldiv_r <= 8'h0;
      hdiv_r <= 8'h0;
      low_sine_addr <= 5'h0;
      high_sine_addr <= 5'h0;
    end else if (ref_tick) begin
      if (ldiv_r >= lterm - 8'd1) begin
        ldiv_r <= 8'h0;
        low_sine_addr <= low_sine_addr + 5'd1;
      end else
        ldiv_r <= ldiv_r + 8'd1;
      if (hdiv_r >= hterm - 8'd1) begin
        hdiv_r <= 8'h0;
        high_sine_addr <= high_sine_addr + 5'd1;
      end else
        hdiv_r <= hdiv_r + 8'd1;
    end
  end

  // tone flags from enable, burst window and single-tone select
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      low_active <= 1'b0;
      high_active <= 1'b0;
    end else begin
      low_active <= tx_on && (!single || !hi_sel);
      high_active <= tx_on && (!single || hi_sel);
    end
  end

  // control, status flags and interrupt pin
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_r <= `DTG_CTL_RESET;
      tx_code_r <= 4'h0;
      dv_r <= 1'b0;
      txrdy_r <= 1'b1;
      irq_dv_r <= 1'b0;
      irq_tx_r <= 1'b0;
      notify_or_progress_pin_oe <= 1'b0;
    end else begin
      if (wr_ctl)
        ctrl_r <= wd[5:0];
      if (wr_tx)
        tx_code_r <= wd[3:0];
      dv_r <= new_rx | (dv_r & !rd_status);
      txrdy_r <= tx_done | (txrdy_r & !wr_tx);
      irq_dv_r <= (new_rx & irq_en) | (irq_dv_r & !rd_status);
      irq_tx_r <= (tx_done & irq_en & !cp_mode) | (irq_tx_r & !rd_status);
      // progress path only in cp mode
      // pin low when out of band and interrupts enabled
      if (cp_mode)
        notify_or_progress_pin_oe <= irq_en & !cp_s2_r;
      else
        notify_or_progress_pin_oe <= irq_dv_r | irq_tx_r;
    end
  end

  // axi write side: hold halves, answer okay or slverr
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 5'h0;
      wdata_r <= 32'h0;
      wstb_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (wr_go) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wa == `DTG_OFF_TXDATA || wa == `DTG_OFF_CTRL) ? 2'b00 : 2'b10;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstb_r <= s_axi_wstrb[0];
      end
      if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // axi read side: one cycle after address
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'b00;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      case (s_axi_araddr)
        `DTG_OFF_CTRL: s_axi_rdata <= {26'h0, ctrl_r};
        `DTG_OFF_STATUS: s_axi_rdata <= {28'h0, !steer_r, dv_r, txrdy_r, irq_dv_r | irq_tx_r};
        `DTG_OFF_RXDATA: s_axi_rdata <= {28'h0, receive_code_bits};
        `DTG_OFF_TONE: s_axi_rdata <= {20'h0, sel8, tx_code_r};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // dtg_tone_ctrl
`default_nettype wire

// ==== dtg_tone_ctrl_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
// port-level checks on bus, steering and sine stepping
module dtg_chk (
  input wire logic clock,
  input wire logic rst,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic steer_guard_pin,
  input wire logic delayed_steer_n,
  input wire logic [3:0] receive_code_bits,
  input wire logic [4:0] low_sine_addr,
  input wire logic [4:0] high_sine_addr
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_bv_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  a_rv_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer moved");
  a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("aw taken while busy");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar taken while busy");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("error read not zero");
  a_steer_pair: assert property (steer_guard_pin == !delayed_steer_n) else $error("steer pins disagree");
  a_rx_latch: assert property ($changed(receive_code_bits) |-> ##[0:2] !delayed_steer_n)
    else $error("code changed without tone");
  a_low_step: assert property (low_sine_addr == $past(low_sine_addr) ||
    low_sine_addr == $past(low_sine_addr) + 5'h01) else $error("low table skipped");
  a_high_step: assert property (high_sine_addr == $past(high_sine_addr) ||
    high_sine_addr == $past(high_sine_addr) + 5'h01) else $error("high table skipped");
  // main scenarios seen
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_tone: cover property ($fell(delayed_steer_n));
  c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // dtg_chk
bind dtg_tone_ctrl dtg_chk u_chk (.*);
`default_nettype wire

// ==== dtg_det_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// detector side: tone present flag, code, in-band square wave
module dtg_det (
  input wire logic clock,
  output logic early_detect_out,
  output logic [3:0] detect_code,
  output logic cp_inband
);
  initial begin
    early_detect_out = 1'b0;
    detect_code = 4'h0;
    cp_inband = 1'b0;
  end
  // tone for n cycles, then g cycles absent
  task tone(input logic [3:0] c, input integer n, input integer g);
    begin
      early_detect_out <= 1'b1;
      detect_code <= c;
      repeat (n) @(posedge clock);
      early_detect_out <= 1'b0;
      // stale code inverted so it is never mistaken for valid
      detect_code <= ~c;
      repeat (g) @(posedge clock);
    end
  endtask
  task inb(input logic v);
    cp_inband <= v;
  endtask
endmodule // dtg_det
`default_nettype wire

// ==== dtg_tone_ctrl_test.sv ====
`timescale 1ns/1ps
`include "dtg_defs.vh"
`default_nettype none
module dtg_tone_ctrl_test;
  logic clock = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0, low_sine_addr, high_sine_addr;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_d;
  logic [3:0] s_axi_wstrb = 4'hF, detect_code, receive_code_bits, code;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_r;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, early_detect_out;
  logic cp_inband, steer_guard_pin, delayed_steer_n, notify_or_progress_pin_oe, low_active, high_active;
  logic [7:0] sc[4] = '{8'h01, 8'h11, 8'h31, 8'h00}; // enable, single low, single high, off
  logic [1:0] se[4] = '{2'h3, 2'h2, 2'h1, 2'h0}; // expected low/high activity
  logic [3:0] rx_q[$]; // model: codes accepted by the receiver
  // model: low and high group tone in hz for each code
  integer flo[16] = '{941, 697, 697, 697, 770, 770, 770, 852, 852, 852, 941, 941, 941, 697, 770, 852};
  integer fhi[16] = '{1633, 1209, 1336, 1477, 1209, 1336, 1477, 1209,
    1336, 1477, 1336, 1209, 1477, 1633, 1633, 1633};
  integer n_errors = 0, check_count = 0, seed = 32'h84ad, m, i;
  wire notify_pin = !notify_or_progress_pin_oe; // open drain with pull-up
  initial forever #12.5 clock = ~clock;
  dtg_tone_ctrl #(.GTP_CYC(20), .GTA_CYC(20), .BURST_CYC(50)) uut (.*);
  dtg_det u_det (.*);
  task chk(input logic [31:0] g, input logic [31:0] e);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task close_out;
    begin
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // segment length against the nominal tone, one percent plus one cycle either way
  task chk_seg(input integer n, input integer f);
    integer e;
    begin
      e = `DTG_CLK_HZ / (`DTG_SEGS * f);
      check_count = check_count + 1;
      if (n < e - e / 100 - 1 || n > e + e / 100 + 1) begin
        n_errors = n_errors + 1;
        $display("wrong value at %0t: segment %0d cycles, nominal %0d", $time, n, e);
      end
    end
  endtask
  // clock cycles between two steps of one sine address, sampled off the edge
  task seg(input logic hi, output integer n);
    logic [4:0] a;
    begin
      @(negedge clock);
      a = hi ? high_sine_addr : low_sine_addr;
      while ((hi ? high_sine_addr : low_sine_addr) == a) @(negedge clock);
      a = hi ? high_sine_addr : low_sine_addr;
      n = 0;
      while ((hi ? high_sine_addr : low_sine_addr) == a) begin
        @(negedge clock);
        n = n + 1;
      end
    end
  endtask
  // ready sampled at negedge, where it stands until the edge
  task wr(input logic [4:0] a, input logic [31:0] d);
    logic pa, pw, ta, tw;
    begin
      pa = 1;
      pw = 1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (pa || pw) begin
        @(negedge clock);
        ta = pa && s_axi_awready;
        tw = pw && s_axi_wready;
        @(posedge clock);
        if (ta) s_axi_awvalid <= 1'b0;
        if (tw) s_axi_wvalid <= 1'b0;
        pa = pa && !ta;
        pw = pw && !tw;
      end
      @(posedge clock);
      s_axi_bready <= 1'b1;
      ta = 0;
      while (!ta) begin
        @(negedge clock);
        ta = s_axi_bvalid;
        @(posedge clock);
      end
      s_axi_bready <= 1'b0;
      @(posedge clock);
    end
  endtask
  task rd(input logic [4:0] a);
    logic p;
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      p = 0;
      while (!p) begin
        @(negedge clock);
        p = s_axi_arready;
        @(posedge clock);
      end
      s_axi_arvalid <= 1'b0;
      @(posedge clock);
      s_axi_rready <= 1'b1;
      p = 0;
      while (!p) begin
        @(negedge clock);
        p = s_axi_rvalid;
        rd_d = s_axi_rdata;
        rd_r = s_axi_rresp;
        @(posedge clock);
      end
      s_axi_rready <= 1'b0;
      @(posedge clock);
    end
  endtask
  // watchdog well past the six and a half thousand or so cycles needed at most
  initial begin
    repeat (20000) @(posedge clock);
    n_errors = n_errors + 1;
    close_out;
  end
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(`DTG_OFF_STATUS);
    chk(rd_d, 32'h0000000A);
    rd(5'h14);
    chk(rd_r, 2'h2);
    chk(rd_d, 32'h0);
    // receive path, interrupts on
    wr(`DTG_OFF_CTRL, 32'h04);
    // strobe off: the control write must not land
    s_axi_wstrb <= 4'h0;
    wr(`DTG_OFF_CTRL, 32'h3F);
    s_axi_wstrb <= 4'hF;
    rd(`DTG_OFF_CTRL);
    chk(rd_d, 32'h00000004);
    i = $random(seed);
    code = i[3:0];
    u_det.tone(code, 10, 30);
    chk(receive_code_bits, 4'h0);
    chk(delayed_steer_n, 1'b1);
    rx_q.push_back(code);
    u_det.tone(code, 40, 5);
    chk(receive_code_bits, rx_q[$]);
    chk(delayed_steer_n, 1'b0);
    chk(notify_pin, 1'b0);
    rd(`DTG_OFF_STATUS);
    chk(rd_d[2:0], 3'h7);
    rd(`DTG_OFF_STATUS);
    chk(rd_d[2:0], 3'h2);
    chk(notify_pin, 1'b1);
    repeat (40) @(posedge clock);
    chk(delayed_steer_n, 1'b1);
    chk(receive_code_bits, rx_q[$]);
    // short dropout keeps the tone
    rx_q.push_back(~code);
    u_det.tone(~code, 30, 5);
    // another code after the gap would show a wrong relatch
    u_det.tone(code, 30, 40);
    chk(receive_code_bits, rx_q[$]);
    rd(`DTG_OFF_STATUS);
    // call-progress mode: no digits, square wave on pin
    wr(`DTG_OFF_CTRL, 32'h06);
    u_det.tone(code, 40, 40);
    chk(receive_code_bits, rx_q[$]);
    u_det.inb(1'b1);
    repeat (5) @(posedge clock);
    chk(notify_pin, 1'b1);
    u_det.inb(1'b0);
    repeat (5) @(posedge clock);
    chk(notify_pin, 1'b0);
    wr(`DTG_OFF_CTRL, 32'h04);
    u_det.inb(1'b1);
    repeat (5) @(posedge clock);
    chk(notify_pin, 1'b1);
    u_det.inb(1'b0);
    repeat (5) @(posedge clock);
    chk(notify_pin, 1'b1);
    // burst, then doubled burst in call-progress mode
    for (m = 1; m < 3; m = m + 1) begin
      // first pass with interrupts on in dual-tone mode
      wr(`DTG_OFF_CTRL, (m == 1) ? 32'h0D : 32'h0B);
      i = $random(seed);
      code = i[3:0];
      wr(`DTG_OFF_TXDATA, {28'h0, code});
      rd(`DTG_OFF_TONE);
      chk(rd_d[3:0], code);
      chk($countones(rd_d[11:4]), 2);
      repeat (25 * m) @(posedge clock);
      chk({low_active, high_active}, 2'h3);
      repeat (50 * m) @(posedge clock);
      chk({low_active, high_active}, 2'h0);
      rd(`DTG_OFF_STATUS);
      chk(rd_d[1], 1'b0);
      repeat (50 * m) @(posedge clock);
      chk(notify_pin, m == 2);
      rd(`DTG_OFF_STATUS);
      chk(rd_d[1], 1'b1);
    end
    // host toggles enable itself, single tones
    for (i = 0; i < 4; i = i + 1) begin
      wr(`DTG_OFF_CTRL, {24'h0, sc[i]});
      repeat (3) @(posedge clock);
      chk({low_active, high_active}, se[i]);
    end
    // segment length of each group for the last code written
    seg(1'b0, i);
    chk_seg(i, flo[code]);
    seg(1'b1, i);
    chk_seg(i, fhi[code]);
    close_out;
  end
endmodule // dtg_tone_ctrl_test
`default_nettype wire
